// ===== verilog/sram_port_pkg.sv
// Constants for the burst-of-two common-I/O SRAM port and its array.
// Assumes the wide organisation: 36-bit data, four 9-bit byte lanes.
package sram_port_pkg;
	// Pin widths
	localparam int DATA_W   = 36;
	localparam int LANE_W   = 9;
	localparam int LANES    = 4;
	localparam int ADDR_W   = 19;
	localparam int BURST    = 2;
	// One array word holds both beats of a burst
	localparam int WORD_W   = DATA_W * BURST;
	localparam int WMASK_W  = LANES * BURST;
	// Synchronised pin vector: k, k_c, load, dir, bypass, addr, bw, data
	localparam int SYNC_W   = 5 + ADDR_W + LANES + DATA_W;
	// Read latency in true-clock cycles
	localparam logic [1:0] RD_LAT_DLL    = 2'h2;
	localparam logic [1:0] RD_LAT_BYPASS = 2'h1;
	// Loop lock time in true-clock cycles
	localparam int LOCK_W          = 12;
	localparam int DLL_LOCK_CYCLES = 2048;
	localparam logic [LOCK_W-1:0] LOCK_LAST =
		LOCK_W'(DLL_LOCK_CYCLES - 1);
endpackage

// ===== verilog/sram_burst_array.sv
// Storage array: one word per burst address, both beats side by side.
// Assumes one write and one read port on the same clock.
`timescale 1ns/1ps
module sram_burst_array (
	// Clock
	input  wire logic                                ref_clk_in,
	// Write port
	input  wire logic                                we_in,
	input  wire logic [sram_port_pkg::ADDR_W-1:0]    waddr_in,
	input  wire logic [sram_port_pkg::WORD_W-1:0]    wdata_in,
	input  wire logic [sram_port_pkg::WMASK_W-1:0]   wmask_in,
	// Read port
	input  wire logic                                re_in,
	input  wire logic [sram_port_pkg::ADDR_W-1:0]    raddr_in,
	output logic      [sram_port_pkg::WORD_W-1:0]    rdata_out
);
	localparam int DEPTH = 1 << sram_port_pkg::ADDR_W;
	localparam int LW    = sram_port_pkg::LANE_W;

	genvar g;
	generate
		for (g = 0; g < sram_port_pkg::WMASK_W; g++) begin : g_lane
			logic [LW-1:0] lane_mem [DEPTH];
			logic [LW-1:0] lane_q_ff;
			// Each lane written only when its enable is set
			always_ff @(posedge ref_clk_in) begin
				if (we_in && wmask_in[g]) begin
					lane_mem[waddr_in] <= wdata_in[g*LW +: LW];
				end
				if (re_in) begin
					lane_q_ff <= lane_mem[raddr_in];
				end
			end
			// One process per lane register; output is a plain wire-up
			assign rdata_out[g*LW +: LW] = lane_q_ff;
		end
	endgenerate
endmodule

// ===== verilog/ddr_burst2_cio_sram_port.sv
// Device side of a burst-of-two DDR common-I/O SRAM port.
// Assumes the input clock pair and all pins arrive asynchronously and
// run far slower than ref_clk_in; each is sampled through two flops.
// Overview of operation
// RULE1 - Address, load and direction captured only on true-clock rising edges.
// RULE2 - Every read and write moves exactly two beats.
// RULE3 - Loop active: first read beat two true edges later, second on k_c.
// RULE4 - Write beats captured at next true edge, then next k_c edge.
// RULE5 - Controller issues at most one operation every other cycle.
// RULE6 - Byte enables sampled with their beat; low enable writes that lane.
// RULE7 - An operation exists only when load strobe is low at true edge.
// RULE8 - With load low, direction high reads and low writes.
// RULE9 - Address ignored on true edges while deselected.
// RULE10 - Echo clocks run continuously, aligned with read data.
// RULE11 - Valid flag marks read data, aligned with the echo clocks.
// RULE12 - Bypass low resets loop and gives one-cycle read latency.
// RULE13 - Bypass high starts loop, locks after the lock time.
// RULE14 - Controller drives k_c ideally in antiphase with true clock.
// RULE15 - Data bus 36 bits wide in the wide organisation.
// RULE16 - Interface runs up to 500 MHz with loop active.
// RULE17 - Reads of the last written addresses see the buffered data.
// RULE18 - Data drivers float whenever no read data is due.
// RULE19 - Controller releases the bus a cycle before new write data.
// RULE20 - Valid rises half cycle before first beat, falls before last.
// RULE21 - Each byte enable governs one nine-bit lane.
`timescale 1ns/1ps
module ddr_burst2_cio_sram_port (
	// Clock and reset
	input  wire logic                              ref_clk_in,
	input  wire logic                              rst_in,
	// Input clock pair
	input  wire logic                              k_in,
	input  wire logic                              k_c_in,
	// Command
	input  wire logic                              load_strobe_n_in,
	input  wire logic                              rw_sel_in,
	input  wire logic [sram_port_pkg::ADDR_W-1:0]  addr_in,
	input  wire logic [sram_port_pkg::LANES-1:0]   byte_write_n_in,
	// Shared data bus
	input  wire logic [sram_port_pkg::DATA_W-1:0]  data_io_in,
	output logic      [sram_port_pkg::DATA_W-1:0]  data_io_out,
	output logic                                   data_io_oe_out,
	// Echo clocks and valid
	output logic                                   echo_clk_t_out,
	output logic                                   echo_clk_c_out,
	output logic                                   out_valid_flag_out,
	// Loop control
	input  wire logic                              loop_bypass_n_in,
	output logic                                   dll_locked_out
);
	localparam int DW = sram_port_pkg::DATA_W;                 // [RULE15]
	localparam int AW = sram_port_pkg::ADDR_W;
	localparam int LN = sram_port_pkg::LANES;
	localparam int WW = sram_port_pkg::WORD_W;
	localparam int MW = sram_port_pkg::WMASK_W;
	localparam int SW = sram_port_pkg::SYNC_W;

	// Expand a lane mask to a bit mask over one array word
	function automatic logic [WW-1:0] lane_bits(input logic [MW-1:0] m);
		logic [WW-1:0] b;
		b = '0;
		for (int i = 0; i < MW; i++) begin
			b[i*sram_port_pkg::LANE_W +: sram_port_pkg::LANE_W] = {
				sram_port_pkg::LANE_W{m[i]}};
		end
		return b;
	endfunction

	// Two-flop synchronisers for every pin; pin rate bound not checked
	// [RULE16]
	logic [SW-1:0] pin_s1_ff;
	logic [SW-1:0] pin_s2_ff;
	logic          k_s3_ff;
	logic          kc_s3_ff;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
			k_s3_ff   <= 1'b0;
			kc_s3_ff  <= 1'b0;
		end else begin
			pin_s1_ff <= {k_in, k_c_in, load_strobe_n_in, rw_sel_in,
				loop_bypass_n_in, addr_in, byte_write_n_in, data_io_in};
			pin_s2_ff <= pin_s1_ff;
			k_s3_ff   <= pin_s2_ff[SW-1];
			kc_s3_ff  <= pin_s2_ff[SW-2];
		end
	end

	logic          k_s;
	logic          kc_s;
	logic          load_n_s;
	logic          dir_s;
	logic          byp_n_s;
	logic [AW-1:0] addr_s;
	logic [LN-1:0] bw_n_s;
	logic [DW-1:0] din_s;
	logic          k_rise;
	logic          kc_rise;

	assign {k_s, kc_s, load_n_s, dir_s, byp_n_s, addr_s, bw_n_s, din_s} =
		pin_s2_ff;
	assign k_rise  = k_s & ~k_s3_ff;
	assign kc_rise = kc_s & ~kc_s3_ff;

	// Write path, read path, output and loop state
	logic                   wr_act_ff, nxt_wr_act;
	logic                   wbeat_ff, nxt_wbeat;
	logic [AW-1:0]          wr_addr_ff, nxt_wr_addr;
	logic [DW-1:0]          cur_lo_ff, nxt_cur_lo;
	logic [LN-1:0]          cur_mlo_ff, nxt_cur_mlo;
	logic                   pend_vld_ff, nxt_pend_vld;
	logic [AW-1:0]          pend_addr_ff, nxt_pend_addr;
	logic [WW-1:0]          pend_data_ff, nxt_pend_data;
	logic [MW-1:0]          pend_mask_ff, nxt_pend_mask;
	logic                   rd_busy_ff, nxt_rd_busy;
	logic [1:0]             rd_due_ff, nxt_rd_due;
	logic [AW-1:0]          rd_addr_ff, nxt_rd_addr;
	logic                   fetch_ff, nxt_fetch;
	logic                   merge_ff, nxt_merge;
	logic [WW-1:0]          rd_word_ff, nxt_rd_word;
	logic [DW-1:0]          dout_ff, nxt_dout;
	logic                   oe_ff, nxt_oe;
	logic                   hi_pend_ff, nxt_hi_pend;
	logic [DW-1:0]          hi_word_ff, nxt_hi_word;
	logic                   valid_ff, nxt_valid;
	logic                   echo_t_ff, echo_c_ff;
	logic [sram_port_pkg::LOCK_W-1:0] lock_cnt_ff, nxt_lock_cnt;
	logic                   locked_ff, nxt_locked;
	logic                   mem_we;
	logic [WW-1:0]          mem_rdata;

	always_comb begin
		nxt_wr_act    = wr_act_ff;
		nxt_wbeat     = wbeat_ff;
		nxt_wr_addr   = wr_addr_ff;
		nxt_cur_lo    = cur_lo_ff;
		nxt_cur_mlo   = cur_mlo_ff;
		nxt_pend_vld  = pend_vld_ff;
		nxt_pend_addr = pend_addr_ff;
		nxt_pend_data = pend_data_ff;
		nxt_pend_mask = pend_mask_ff;
		nxt_rd_busy   = rd_busy_ff;
		nxt_rd_due    = rd_due_ff;
		nxt_rd_addr   = rd_addr_ff;
		nxt_fetch     = 1'b0;
		nxt_merge     = fetch_ff;
		nxt_rd_word   = rd_word_ff;
		nxt_dout      = dout_ff;
		nxt_oe        = oe_ff;
		nxt_hi_pend   = hi_pend_ff;
		nxt_hi_word   = hi_word_ff;
		nxt_valid     = valid_ff;
		nxt_lock_cnt  = lock_cnt_ff;
		nxt_locked    = locked_ff;
		mem_we        = 1'b0;

		if (k_rise) begin
			// First write beat with its lane enables
			if (wr_act_ff && !wbeat_ff) begin                  // [RULE4]
				nxt_cur_lo  = din_s;
				nxt_cur_mlo = ~bw_n_s;                           // [RULE6] [RULE21]
				nxt_wbeat   = 1'b1;
			end
			// Valid drops half a cycle ahead of the last beat
			nxt_valid = 1'b0;                                    // [RULE20]
			nxt_oe    = 1'b0;                                    // [RULE18]
			if (rd_busy_ff && rd_due_ff == 2'h1) begin           // [RULE3]
				nxt_dout    = rd_word_ff[DW-1:0];
				nxt_hi_word = rd_word_ff[WW-1:DW];
				nxt_hi_pend = 1'b1;
				nxt_oe      = 1'b1;
				nxt_rd_busy = 1'b0;
			end else if (rd_busy_ff) begin
				nxt_rd_due = rd_due_ff - 2'h1;
			end
			// New operation only when loaded; address ignored otherwise
			if (!load_n_s) begin                               // [RULE1] [RULE7] [RULE9]
				if (dir_s) begin                                 // [RULE8]
					nxt_rd_busy = 1'b1;
					nxt_rd_addr = addr_s;
					nxt_fetch   = 1'b1;
					nxt_rd_due  = byp_n_s ? sram_port_pkg::RD_LAT_DLL
						: sram_port_pkg::RD_LAT_BYPASS;              // [RULE12]
				end else begin
					nxt_wr_act  = 1'b1;
					nxt_wbeat   = 1'b0;
					nxt_wr_addr = addr_s;
				end
			end
		end

		if (kc_rise) begin
			// Second write beat completes the burst
			if (wr_act_ff && wbeat_ff) begin                     // [RULE2] [RULE4]
				mem_we        = pend_vld_ff;                       // [RULE17]
				nxt_pend_vld  = 1'b1;
				nxt_pend_addr = wr_addr_ff;
				nxt_pend_data = {din_s, cur_lo_ff};
				nxt_pend_mask = {~bw_n_s, cur_mlo_ff};             // [RULE6]
				nxt_wr_act    = 1'b0;
			end
			if (hi_pend_ff) begin                                // [RULE3]
				nxt_dout    = hi_word_ff;
				nxt_hi_pend = 1'b0;
			end
			if (rd_busy_ff && rd_due_ff == 2'h1) begin           // [RULE20]
				nxt_valid = 1'b1;
			end
		end

		// Buffered write data overrides the array on a hit
		if (merge_ff) begin                                    // [RULE17]
			if (pend_vld_ff && pend_addr_ff == rd_addr_ff) begin
				nxt_rd_word = (mem_rdata & ~lane_bits(pend_mask_ff)) |
					(pend_data_ff & lane_bits(pend_mask_ff));
			end else begin
				nxt_rd_word = mem_rdata;
			end
		end

		// Loop held in reset while bypassed
		if (!byp_n_s) begin                                    // [RULE12]
			nxt_lock_cnt = '0;
			nxt_locked   = 1'b0;
		end else if (k_rise && !locked_ff) begin               // [RULE13]
			nxt_lock_cnt = lock_cnt_ff + 1'b1;
			nxt_locked   = (lock_cnt_ff == sram_port_pkg::LOCK_LAST);
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_act_ff    <= 1'b0;
			wbeat_ff     <= 1'b0;
			wr_addr_ff   <= '0;
			cur_lo_ff    <= '0;
			cur_mlo_ff   <= '0;
			pend_vld_ff  <= 1'b0;
			pend_addr_ff <= '0;
			pend_data_ff <= '0;
			pend_mask_ff <= '0;
			rd_busy_ff   <= 1'b0;
			rd_due_ff    <= 2'h0;
			rd_addr_ff   <= '0;
			fetch_ff     <= 1'b0;
			merge_ff     <= 1'b0;
			rd_word_ff   <= '0;
			dout_ff      <= '0;
			oe_ff        <= 1'b0;
			hi_pend_ff   <= 1'b0;
			hi_word_ff   <= '0;
			valid_ff     <= 1'b0;
			echo_t_ff    <= 1'b0;
			echo_c_ff    <= 1'b0;
			lock_cnt_ff  <= '0;
			locked_ff    <= 1'b0;
		end else begin
			wr_act_ff    <= nxt_wr_act;
			wbeat_ff     <= nxt_wbeat;
			wr_addr_ff   <= nxt_wr_addr;
			cur_lo_ff    <= nxt_cur_lo;
			cur_mlo_ff   <= nxt_cur_mlo;
			pend_vld_ff  <= nxt_pend_vld;
			pend_addr_ff <= nxt_pend_addr;
			pend_data_ff <= nxt_pend_data;
			pend_mask_ff <= nxt_pend_mask;
			rd_busy_ff   <= nxt_rd_busy;
			rd_due_ff    <= nxt_rd_due;
			rd_addr_ff   <= nxt_rd_addr;
			fetch_ff     <= nxt_fetch;
			merge_ff     <= nxt_merge;
			rd_word_ff   <= nxt_rd_word;
			dout_ff      <= nxt_dout;
			oe_ff        <= nxt_oe;
			hi_pend_ff   <= nxt_hi_pend;
			hi_word_ff   <= nxt_hi_word;
			valid_ff     <= nxt_valid;
			// Echo edges land on the same clock as the data update
			echo_t_ff    <= k_s;                                  // [RULE10]
			echo_c_ff    <= kc_s;                                 // [RULE10]
			lock_cnt_ff  <= nxt_lock_cnt;
			locked_ff    <= nxt_locked;
		end
	end

	sram_burst_array u_array (
		.ref_clk_in (ref_clk_in),
		.we_in      (mem_we),
		.waddr_in   (pend_addr_ff),
		.wdata_in   (pend_data_ff),
		.wmask_in   (pend_mask_ff),
		.re_in      (fetch_ff),
		.raddr_in   (rd_addr_ff),
		.rdata_out  (mem_rdata)
	);

	assign data_io_out        = dout_ff;
	assign data_io_oe_out     = oe_ff;
	assign echo_clk_t_out     = echo_t_ff;
	assign echo_clk_c_out     = echo_c_ff;
	assign out_valid_flag_out = valid_ff;
	assign dll_locked_out     = locked_ff;

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);

	a_echo_true_rise: assert property (k_rise |=> echo_clk_t_out) // [RULE10]
		else $error("true echo did not follow input clock");
	a_echo_comp_rise: assert property (kc_rise |=> echo_clk_c_out) // [RULE10]
		else $error("comp echo did not follow input clock");
	a_oe_on_true_edge: assert property ($rose(data_io_oe_out) |->
		$past(k_rise) && echo_clk_t_out) // [RULE3]
		else $error("data drive began off a true edge");
	a_valid_before_data: assert property ($rose(data_io_oe_out) |->
		$past(out_valid_flag_out)) // [RULE20]
		else $error("data driven without leading valid");
	a_valid_rise_comp: assert property ($rose(out_valid_flag_out) |->
		$past(kc_rise) && echo_clk_c_out) // [RULE11]
		else $error("valid rose off a comp echo edge");
	a_valid_fall_beat: assert property ($fell(out_valid_flag_out) |->
		data_io_oe_out && $past(k_rise)) // [RULE20]
		else $error("valid fell away from first beat");
	a_oe_burst_only: assert property (data_io_oe_out && $past(k_rise) |->
		!$past(hi_pend_ff)) // [RULE18]
		else $error("bus driven outside a burst");
	a_addr_ignored: assert property (k_rise && load_n_s |=>
		$stable(rd_addr_ff) && $stable(wr_addr_ff)) // [RULE9]
		else $error("address taken while deselected");
	a_read_direction: assert property (k_rise && !load_n_s && dir_s |=>
		rd_busy_ff && rd_addr_ff == $past(addr_s)) // [RULE8]
		else $error("read command not taken");
	a_bypass_latency: assert property (k_rise && !load_n_s && dir_s &&
		!byp_n_s |=> rd_due_ff == 2'h1) // [RULE12]
		else $error("bypass latency not one cycle");
	a_dll_latency: assert property (k_rise && !load_n_s && dir_s &&
		byp_n_s |=> rd_due_ff == 2'h2) // [RULE3]
		else $error("loop latency not two cycles");
	a_loop_reset: assert property (!byp_n_s |=>
		!dll_locked_out && lock_cnt_ff == '0) // [RULE12]
		else $error("loop not held in reset");
	a_second_beat: assert property (kc_rise && hi_pend_ff |=>
		!hi_pend_ff && data_io_out == $past(hi_word_ff)) // [RULE2]
		else $error("second read beat not presented");
endmodule

// ===== dv/sram_ctrl_model.sv
// Controller model: input clock pair, commands and write beats.
// Assumes a single caller issuing its tasks back to back.
`timescale 1ns/1ps
module sram_ctrl_model (
	// Pins toward the device
	output logic					k_out,
	output logic					k_c_out,
	output logic					load_strobe_n_out,
	output logic					rw_sel_out,
	output logic [sram_port_pkg::ADDR_W-1:0]	addr_out,
	output logic [sram_port_pkg::LANES-1:0]		byte_write_n_out,
	// Resolved shared bus
	output logic [sram_port_pkg::DATA_W-1:0]	bus_out,
	input  wire logic [sram_port_pkg::DATA_W-1:0]	dev_data_in,
	input  wire logic				dev_oe_in
);
	logic [sram_port_pkg::DATA_W-1:0]	drv_data;
	logic [sram_port_pkg::DATA_W-1:0]	float_data;
	logic					drv_oe;
	logic					rel;
	int					k_count;
	event					before_k;
	event					before_kc;

	// Nobody driving: a pattern that flips every half period
	assign bus_out = dev_oe_in ? (drv_oe ? 'x : dev_data_in)
		: (drv_oe ? drv_data : float_data);

	initial begin
		{k_out, k_c_out, load_strobe_n_out, rw_sel_out} = 4'h7;
		addr_out = '0;
		byte_write_n_out = '1;
		drv_data = '0;
		float_data = '0;
		{drv_oe, rel} = 2'h0;
		k_count = 0;
		#7.3;
		forever begin
			{k_out, k_c_out} = 2'h2;
			k_count++;
			#31.25;
			float_data = ~float_data;
			-> before_kc;
			#31.25;
			{k_out, k_c_out} = 2'h1;
			#31.25;
			float_data = ~float_data;
			if (rel) {drv_oe, rel} = 2'h0;
			-> before_k;
			#31.25;
		end
	end

	// One burst; occupies two true-clock cycles
	task automatic op(input logic rd,
			input logic [sram_port_pkg::ADDR_W-1:0] a,
			input logic [sram_port_pkg::WORD_W-1:0] w,
			input logic [sram_port_pkg::WMASK_W-1:0] bw_n);
		@(before_k);
		{load_strobe_n_out, rw_sel_out} = {1'b0, rd};
		addr_out = a;
		@(before_kc);
		// Junk held over the complementary edge
		rw_sel_out = ~rd;
		addr_out = ~a;
		@(before_k);
		load_strobe_n_out = 1'b1;
		if (!rd) begin
			{drv_oe, drv_data} = {1'b1, w[35:0]};
			byte_write_n_out = bw_n[3:0];
		end
		@(before_kc);
		drv_data = w[71:36];
		byte_write_n_out = bw_n[7:4];
		rel = !rd;
	endtask

	task automatic idle();
		@(before_k);
		load_strobe_n_out = 1'b1;
		addr_out = ~addr_out;
		@(before_kc);
	endtask
endmodule

// ===== dv/ddr_burst2_cio_sram_port_bench.sv
// Bench for the burst-of-two SRAM port driven by a controller model.
// Assumes the design package and the controller model compile first.
`timescale 1ns/1ps
module ddr_burst2_cio_sram_port_bench;
	typedef struct {
		logic [71:0]	d;
		int		k;
	} note_t;
	logic		ref_clk_in;
	logic		rst_in;
	logic		loop_bypass_n_in;
	logic		k_in;
	logic		k_c_in;
	logic		load_strobe_n_in;
	logic		rw_sel_in;
	logic [18:0]	addr_in;
	logic [3:0]	byte_write_n_in;
	logic [35:0]	data_io_in;
	logic [35:0]	data_io_out;
	logic		data_io_oe_out;
	logic		echo_clk_t_out;
	logic		echo_clk_c_out;
	logic		out_valid_flag_out;
	logic		dll_locked_out;
	note_t		notes[$];
	note_t		cur;
	logic [71:0]	mem [int];
	logic [35:0]	beat1;
	logic		oe_q, vld_q, ec_q, et_q;
	int		failures, tests_run, lat, seed, echo_n, k0, e0;

	sram_ctrl_model ctrl (.k_out(k_in), .k_c_out(k_c_in),
		.load_strobe_n_out(load_strobe_n_in), .rw_sel_out(rw_sel_in),
		.addr_out(addr_in), .byte_write_n_out(byte_write_n_in),
		.bus_out(data_io_in), .dev_data_in(data_io_out),
		.dev_oe_in(data_io_oe_out));
	ddr_burst2_cio_sram_port dut (.ref_clk_in(ref_clk_in),
		.rst_in(rst_in), .k_in(k_in), .k_c_in(k_c_in),
		.load_strobe_n_in(load_strobe_n_in), .rw_sel_in(rw_sel_in),
		.addr_in(addr_in), .byte_write_n_in(byte_write_n_in),
		.data_io_in(data_io_in), .data_io_out(data_io_out),
		.data_io_oe_out(data_io_oe_out),
		.echo_clk_t_out(echo_clk_t_out),
		.echo_clk_c_out(echo_clk_c_out),
		.out_valid_flag_out(out_valid_flag_out),
		.loop_bypass_n_in(loop_bypass_n_in),
		.dll_locked_out(dll_locked_out));

	initial begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end

	task automatic check(input string nm, input logic [71:0] e,
			input logic [71:0] g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	function automatic logic [71:0] rnd72();
		return {$random(seed), $random(seed), 8'($random(seed))};
	endfunction

	task automatic wr(input int a, input logic [71:0] w,
			input logic [7:0] bw);
		for (int i = 0; i < 8; i++)
			if (!bw[i]) mem[a][9*i+:9] = w[9*i+:9];
		ctrl.op(1'b0, 19'(a), w, bw);
	endtask

	task automatic rd(input int a);
		notes.push_back('{mem[a], ctrl.k_count + 1 + lat});
		ctrl.op(1'b1, 19'(a), '0, '1);
	endtask

	// Watcher: pairs each read burst on the pins with its note
	always @(posedge ref_clk_in) begin
		if (echo_clk_t_out && !et_q) echo_n++;
		if (out_valid_flag_out && !vld_q)
			check("valid edge", 72'h1, 72'(echo_clk_c_out && !ec_q));
		if (data_io_oe_out && !oe_q) begin
			if (notes.size() == 0) check("stray oe", 72'h0, 72'h1);
			else begin
				cur = notes.pop_front();
				check("beat0", 72'(cur.d[35:0]), 72'(data_io_out));
				check("latency", 72'(cur.k), 72'(ctrl.k_count));
				check("valid", 72'h2, 72'({vld_q, out_valid_flag_out}));
				beat1 = cur.d[71:36];
			end
		end
		if (echo_clk_c_out && !ec_q && data_io_oe_out)
			check("beat1", 72'(beat1), 72'(data_io_out));
		oe_q <= data_io_oe_out;
		vld_q <= out_valid_flag_out;
		ec_q <= echo_clk_c_out;
		et_q <= echo_clk_t_out;
	end

	initial begin
		#800000;
		failures++;
		report_and_stop();
	end

	initial begin
		seed = 32'h3d7af123;
		{failures, tests_run, echo_n, lat} = {32'h0, 32'h0, 32'h0, 32'h2};
		{oe_q, vld_q, ec_q, et_q} = 4'h0;
		rst_in = 1'b1;
		loop_bypass_n_in = 1'b1;
		repeat (3) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		ctrl.idle();
		ctrl.idle();
		for (int a = 0; a < 8; a++) wr(a, rnd72(), 8'h00);
		for (int a = 7; a >= 0; a--) rd(a);
		$display("test fill done");
		for (int i = 0; i < 9; i++) begin
			ctrl.idle();
			ctrl.idle();
			wr(3, rnd72(), i < 8 ? ~(8'h01 << i) : 8'hff);
			rd(3);
		end
		for (int a = 0; a < 8; a++) rd(a);
		$display("test lanes done");
		#40;
		{k0, e0} = {ctrl.k_count, echo_n};
		repeat (20) ctrl.idle();
		#40;
		check("echo count", 72'(ctrl.k_count - k0), 72'(echo_n - e0));
		check("locked early", 72'h0, 72'(dll_locked_out));
		$display("test idle done");
		@(posedge ref_clk_in);
		loop_bypass_n_in <= 1'b0;
		repeat (3) ctrl.idle();
		lat = 1;
		repeat (6) rd({$random(seed)} % 8);
		repeat (3) ctrl.idle();
		check("locked bypass", 72'h0, 72'(dll_locked_out));
		$display("test bypass done");
		@(posedge ref_clk_in);
		loop_bypass_n_in <= 1'b1;
		k0 = ctrl.k_count;
		repeat (3) ctrl.idle();
		lat = 2;
		while (dll_locked_out !== 1'b1 && ctrl.k_count - k0 < 2100)
			ctrl.idle();
		check("lock time", 72'h1, 72'(dll_locked_out === 1'b1 &&
			ctrl.k_count - k0 >= 2048 && ctrl.k_count - k0 <= 2052));
		repeat (6) rd({$random(seed)} % 8);
		repeat (4) ctrl.idle();
		check("notes left", 72'h0, 72'(notes.size()));
		$display("test lock done");
		report_and_stop();
	end
endmodule
